// >>> pkg/sep_map.svh
// offsets, field positions, reset values and timing counts of the eeprom slave
`ifndef SEP_MAP_SVH
`define SEP_MAP_SVH

`define SEP_CLK_MHZ      200
`define SEP_TWR_MS       10
`define SEP_TWR_CYCLES   (`SEP_TWR_MS * 1000 * `SEP_CLK_MHZ)
`define SEP_MEM_BYTES    2048
`define SEP_ADDR_W       11
`define SEP_ADDR_RST     11'h000
`define SEP_PAGE_BYTES   16
`define SEP_PG_LSB       4
`define SEP_BLK_LSB      8
`define SEP_CTRL_LEAD    1'b1
`define SEP_PIN_SDA      0
`define SEP_PIN_SCL      1
`define SEP_PIN_SEL_LO   2
`define SEP_PIN_SEL_MID  3
`define SEP_PIN_SEL_HI   4
`define SEP_PIN_WP       5
`define SEP_PIN_N        6
`define SEP_PIN_RST      6'h3f

`endif

// >>> pkg/sep_pkg.sv
// types of the eeprom slave
`default_nettype none
package sep_pkg;

    typedef enum logic [2:0] {
        SEP_ST_IDLE = 3'b000,
        SEP_ST_RX   = 3'b001,
        SEP_ST_ACKW = 3'b010,
        SEP_ST_ACKH = 3'b011,
        SEP_ST_TX   = 3'b100,
        SEP_ST_TXA  = 3'b101
    } sep_state_t;

    typedef enum logic [1:0] {
        SEP_PH_CTRL  = 2'b00,
        SEP_PH_WADDR = 2'b01,
        SEP_PH_DATA  = 2'b10,
        SEP_PH_READ  = 2'b11
    } sep_phase_t;

    typedef struct packed {
        logic tgl;
        logic bit_v;
    } sep_link_t;

endpackage : sep_pkg
`default_nettype wire

// >>> src/sep_eeprom_slave.sv
// two-wire serial eeprom slave: protocol engine, page buffer and array
`timescale 1ns/100ps
`default_nettype none
`include "sep_map.svh"
// How it works
// R01 - data falling while clock high is a start condition
// R02 - data rising while clock high is a stop condition
// R03 - data changes only while clock low; bits sampled on clock rise
// R04 - master starts transfers only when both lines idle high
// R05 - master gives one clock pulse per data bit
// R06 - addressed receiver holds data low through the ninth clock high
// R07 - no acknowledge at all while a programming cycle runs
// R08 - master nack on read ends transmission; data line released
// R09 - control byte: lead one, chip select vs straps, middle inverted
// R10 - three block bits form the top of the word address
// R11 - last control bit: one reads, zero writes
// R12 - after write control byte, next byte loads the address pointer
// R13 - data byte acknowledged; stop then starts the self-timed write
// R14 - up to sixteen bytes held in page buffer, committed after stop
// R15 - only the four low pointer bits increment per data byte
// R16 - beyond sixteen bytes the page wraps, last sixteen kept
// R17 - control byte nacked while busy, acknowledged once done
// R18 - write protect high inhibits all programming, reads unaffected
// R19 - address counter holds last address plus one
// R20 - read control byte acknowledged, then one byte shifted out
// R21 - msb first; data line only pulled low, otherwise released
// R22 - mismatching control byte: no ack, ignore until next start
// R23 - start in mid transfer restarts with a fresh control byte
module sep_eeprom_slave
    import sep_pkg::*;
#(
    parameter int WR_CYCLES = `SEP_TWR_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic scl_clk,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    input  wire logic chip_sel_strap_low,
    input  wire logic chip_sel_strap_mid_inverted,
    input  wire logic chip_sel_strap_high,
    input  wire logic wp,
    output logic      busy
);

    localparam int AW = `SEP_ADDR_W;
    localparam int PN = `SEP_PIN_N;
    localparam int TW = $clog2(WR_CYCLES + 1);
    localparam logic [TW-1:0] TWR_LOAD = TW'(WR_CYCLES - 1);

    typedef struct packed {
        logic [PN-1:0]                         pin1;
        logic [PN-1:0]                         pin2;
        logic [PN-1:0]                         pin3;
        logic [PN-1:0]                         pins;
        logic                                  tg1;
        logic                                  tg2;
        logic                                  tg3;
        logic                                  tg_seen;
        sep_state_t                            st;
        sep_phase_t                            ph;
        logic [3:0]                            cnt;
        logic [7:0]                            sh;
        logic [AW-1:0]                         addr;
        logic [`SEP_PAGE_BYTES-1:0][7:0]       pbuf;
        logic [`SEP_PAGE_BYTES-1:0]            pmask;
        logic                                  busy;
        logic [TW-1:0]                         timer;
        logic                                  oe_n;
        logic                                  sda_o;
        logic [`SEP_MEM_BYTES-1:0][7:0]        mem;
    } sep_core_t;

    sep_core_t q;
    sep_core_t d;
    sep_link_t lk_q;

    logic          start_ev;
    logic          stop_ev;
    logic          scl_fall;
    logic          bit_ev;
    logic [7:0]    byte_v;
    logic [3:0]    sel_code;

    // ------------------------------------------------------------------
    // link side: capture each bit on the serial clock rise
    // ------------------------------------------------------------------
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            lk_q <= '0;
        end else begin
            lk_q.tgl   <= ~lk_q.tgl;
            lk_q.bit_v <= sda_in; // R03
        end
    end

    // ------------------------------------------------------------------
    // core: pin sampling, protocol engine, page buffer, write cycle
    // ------------------------------------------------------------------
    function automatic sep_core_t load_read(input sep_core_t s);
        sep_core_t r;
        r      = s;
        r.sh   = s.mem[s.addr];
        r.oe_n = s.mem[s.addr][7]; // R21
        r.addr = s.addr + 1'b1; // R19
        r.cnt  = 4'h0;
        r.st   = SEP_ST_TX; // R20
        return r;
    endfunction : load_read

    always_comb begin
        d      = q;
        d.pin1 = {wp, chip_sel_strap_high, chip_sel_strap_mid_inverted,
                  chip_sel_strap_low, scl_clk, sda_in};
        d.pin2 = q.pin1;
        d.pin3 = q.pin2;
        for (int i = 0; i < PN; i++) begin
            if (q.pin2[i] == q.pin3[i]) begin
                d.pins[i] = q.pin3[i];
            end
        end
        d.tg1 = lk_q.tgl;
        d.tg2 = q.tg1;
        d.tg3 = q.tg2;
        bit_ev = (q.tg2 == q.tg3) && (q.tg3 != q.tg_seen);
        if (bit_ev) begin
            d.tg_seen = q.tg3;
        end
        start_ev = q.pins[`SEP_PIN_SCL] && d.pins[`SEP_PIN_SCL]
                   && q.pins[`SEP_PIN_SDA] && !d.pins[`SEP_PIN_SDA]; // R01
        stop_ev  = q.pins[`SEP_PIN_SCL] && d.pins[`SEP_PIN_SCL]
                   && !q.pins[`SEP_PIN_SDA] && d.pins[`SEP_PIN_SDA]; // R02
        scl_fall = q.pins[`SEP_PIN_SCL] && !d.pins[`SEP_PIN_SCL];
        byte_v   = {q.sh[6:0], lk_q.bit_v}; // R21
        sel_code = {`SEP_CTRL_LEAD, q.pins[`SEP_PIN_SEL_HI],
                    ~q.pins[`SEP_PIN_SEL_MID], q.pins[`SEP_PIN_SEL_LO]};

        if (q.busy) begin
            if (q.timer == '0) begin
                d.busy = 1'b0;
            end else begin
                d.timer = q.timer - 1'b1;
            end
        end

        unique case (q.st)
            SEP_ST_IDLE: begin
                d.oe_n = 1'b1;
            end
            SEP_ST_RX: begin
                if (bit_ev) begin
                    d.sh  = byte_v;
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == 4'h7) begin
                        d.cnt = 4'h0;
                        d.st  = SEP_ST_ACKW;
                        unique case (q.ph)
                            SEP_PH_CTRL: begin
                                if (byte_v[7:4] == sel_code && !q.busy) begin // R09 R07 R17
                                    d.addr[AW-1:`SEP_BLK_LSB] = byte_v[3:1]; // R10
                                    d.ph = byte_v[0] ? SEP_PH_READ : SEP_PH_WADDR; // R11
                                end else begin
                                    d.st = SEP_ST_IDLE; // R22
                                end
                            end
                            SEP_PH_WADDR: begin
                                d.addr[`SEP_BLK_LSB-1:0] = byte_v; // R12
                                d.ph = SEP_PH_DATA;
                            end
                            SEP_PH_DATA: begin
                                d.pbuf[q.addr[`SEP_PG_LSB-1:0]]  = byte_v; // R14 R16
                                d.pmask[q.addr[`SEP_PG_LSB-1:0]] = 1'b1;
                                d.addr[`SEP_PG_LSB-1:0] =
                                    q.addr[`SEP_PG_LSB-1:0] + 1'b1; // R15
                            end
                            SEP_PH_READ: begin
                                d.st = SEP_ST_IDLE;
                            end
                        endcase
                    end
                end
            end
            SEP_ST_ACKW: begin
                if (scl_fall) begin
                    d.oe_n = 1'b0; // R06
                    d.st   = SEP_ST_ACKH;
                end
            end
            SEP_ST_ACKH: begin
                if (scl_fall) begin
                    if (q.ph == SEP_PH_READ) begin
                        d = load_read(d);
                    end else begin
                        d.oe_n = 1'b1;
                        d.st   = SEP_ST_RX;
                    end
                end
            end
            SEP_ST_TX: begin
                if (bit_ev) begin
                    d.cnt = q.cnt + 4'h1;
                end
                if (scl_fall) begin
                    if (q.cnt == 4'h8) begin
                        d.oe_n = 1'b1;
                        d.st   = SEP_ST_TXA;
                    end else begin
                        d.sh   = {q.sh[6:0], 1'b0};
                        d.oe_n = q.sh[6]; // R03 R21
                    end
                end
            end
            SEP_ST_TXA: begin
                if (bit_ev) begin
                    d.st = lk_q.bit_v ? SEP_ST_IDLE : SEP_ST_ACKH; // R08
                end
            end
            default: begin
                d.st   = SEP_ST_IDLE;
                d.oe_n = 1'b1;
            end
        endcase

        if (stop_ev) begin
            if (q.ph == SEP_PH_DATA && q.pmask != '0 && !q.pins[`SEP_PIN_WP]) begin // R18
                for (int i = 0; i < `SEP_PAGE_BYTES; i++) begin
                    if (q.pmask[i]) begin
                        d.mem[{q.addr[AW-1:`SEP_PG_LSB], 4'(i)}] = q.pbuf[i]; // R14
                    end
                end
                d.busy  = 1'b1; // R13
                d.timer = TWR_LOAD;
            end
            d.pmask = '0;
            d.ph    = SEP_PH_CTRL;
            d.oe_n  = 1'b1;
            d.st    = SEP_ST_IDLE;
        end else if (start_ev) begin
            d.pmask = '0;
            d.ph    = SEP_PH_CTRL; // R23
            d.cnt   = 4'h0;
            d.oe_n  = 1'b1;
            d.st    = SEP_ST_RX;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q       <= '0;
            q.pin1  <= `SEP_PIN_RST;
            q.pin2  <= `SEP_PIN_RST;
            q.pin3  <= `SEP_PIN_RST;
            q.pins  <= `SEP_PIN_RST;
            q.st    <= SEP_ST_IDLE;
            q.ph    <= SEP_PH_CTRL;
            q.addr  <= `SEP_ADDR_RST;
            q.oe_n  <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign sda_out  = q.sda_o;
    assign sda_oe_n = q.oe_n;
    assign busy     = q.busy;

endmodule : sep_eeprom_slave
`default_nettype wire

// >>> testbench/sep_eeprom_slave_properties.sv
// pin-level assertions of the eeprom slave
`timescale 1ns/100ps
`default_nettype none
`include "sep_map.svh"
module sep_eeprom_slave_properties #(
    parameter int WR_CYCLES = `SEP_TWR_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic wp,
    input wire logic busy
);
    // --------
    // write time counter, frozen while ce is low
    // --------
    logic [31:0] cnt_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= busy ? cnt_q + 32'(ce) : '0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence stop_seen;
        scl_clk && sda_in && !$past(sda_in, 8);
    endsequence
    sequence after_fall;
        !scl_clk && !$past(scl_clk, 3) && $past(scl_clk, 7);
    endsequence
    AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
        else $error("data output not low");
    AST_NO_ACK_BUSY: assert property (busy |-> sda_oe_n)
        else $error("data driven while busy");
    AST_EDGE_AFTER_FALL: assert property ($changed(sda_oe_n) |-> after_fall)
        else $error("drive changed outside clock low");
    AST_DRIVE_HOLD: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
        else $error("drive too short");
    AST_BUSY_HOLD: assert property ($rose(busy) |-> busy [*8])
        else $error("busy too short");
    AST_WR_TIME: assert property ($fell(busy) |-> cnt_q == WR_CYCLES)
        else $error("write time wrong");
    AST_BUSY_AFTER_STOP: assert property ($rose(busy) |-> stop_seen)
        else $error("write began without stop");
    AST_WP_BLOCKS: assert property ($rose(busy) |-> !wp && !$past(wp, 8))
        else $error("write under protect");
endmodule : sep_eeprom_slave_properties
bind sep_eeprom_slave sep_eeprom_slave_properties #(.WR_CYCLES(WR_CYCLES)) props_i (
    .clk(clk), .rst(rst), .ce(ce), .scl_clk(scl_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wp(wp), .busy(busy));
`default_nettype wire

// >>> testbench/sep_master_model.sv
// two-wire bus master model driving the serial clock
`timescale 1ns/100ps
`default_nettype none
module sep_master_model (
    output logic      scl_clk,
    output logic      sda_low,
    input  wire logic sda
);
    // --------
    // own 15 ns time base, free in phase
    // --------
    logic lclk = 1'b0;
    // offset start keeps the link edges off the core clock edges
    initial begin
        #0.7;
        forever #7.5 lclk = ~lclk;
    end
    initial begin
        scl_clk = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hp();
        repeat (40) @(posedge lclk);
    endtask : hp
    task automatic start();
        @(posedge lclk);
        sda_low = 1'b0;
        hp();
        scl_clk = 1'b1;
        hp();
        sda_low = 1'b1;
        hp();
        scl_clk = 1'b0;
    endtask : start
    task automatic stop();
        @(posedge lclk);
        sda_low = 1'b1;
        hp();
        scl_clk = 1'b1;
        hp();
        sda_low = 1'b0;
        hp();
    endtask : stop
    task automatic bitx(input logic b, output logic r);
        @(posedge lclk);
        sda_low = ~b;
        hp();
        scl_clk = 1'b1;
        hp();
        r = sda;
        scl_clk = 1'b0;
    endtask : bitx
    task automatic wr(input logic [7:0] v, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(v[i], r);
        end
        bitx(1'b1, r);
        a = ~r;
    endtask : wr
    task automatic rd(input logic a, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            v[i] = r;
        end
        bitx(~a, r);
    endtask : rd
endmodule : sep_master_model
`default_nettype wire

// >>> testbench/sep_eeprom_slave_bench.sv
// self-checking bench of the eeprom slave
`timescale 1ns/100ps
`default_nettype none
module sep_eeprom_slave_bench;
    localparam int WR = 6000;
    logic clk = 1'b0, rst = 1'b0, ce = 1'b1, wp = 1'b0;
    logic [2:0] sel = 3'h0, blk;
    logic scl_clk, sda_low, sda_out, sda_oe_n, busy, ack;
    logic [7:0] mem [2048], d;
    logic [10:0] base, ra;
    int bad_count = 0, total_checks = 0;
    wire sda_in = !(sda_low || sda_oe_n === 1'b0);
    always #2.5 clk = ~clk;
    sep_eeprom_slave #(.WR_CYCLES(WR)) sep_eeprom_slave_i (
        .clk(clk), .rst(rst), .ce(ce), .scl_clk(scl_clk), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_sel_strap_low(sel[0]),
        .chip_sel_strap_mid_inverted(sel[1]), .chip_sel_strap_high(sel[2]),
        .wp(wp), .busy(busy));
    sep_master_model sep_master_model_i (.scl_clk(scl_clk), .sda_low(sda_low), .sda(sda_in));
    // --------
    // expectations and checks
    // --------
    function automatic logic [7:0] ctl(input logic [2:0] b, input logic rw);
        return {1'b1, sel[2], ~sel[1], sel[0], b, rw};
    endfunction : ctl
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic put(input logic [7:0] v, input logic a);
        sep_master_model_i.wr(v, ack);
        chk({7'h00, ack}, {7'h00, a});
    endtask : put
    task automatic wstart();
        sep_master_model_i.start();
        put(ctl(blk, 1'b0), 1'b1);
        put(base[7:0], 1'b1);
    endtask : wstart
    task automatic rread(input int n);
        sep_master_model_i.start();
        put(ctl(blk, 1'b1), 1'b1);
        ra[10:8] = blk;
        for (int i = 0; i < n; i++) begin
            sep_master_model_i.rd(i < n - 1, d);
            chk(d, mem[ra]);
            ra++;
        end
        chk({7'h00, sda_oe_n}, 8'h01);
        sep_master_model_i.stop();
    endtask : rread
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 9000) begin
            @(negedge clk);
            ce = ($urandom % 8) != 0;
            n++;
        end
        @(negedge clk);
        ce = 1'b1;
        chk({7'h00, busy}, {7'h00, lvl});
        if (busy !== lvl) begin
            finish_test();
        end
    endtask : wait_busy
    initial begin
        void'($urandom(32'hb2f8_05bc));
        sel = 3'($urandom);
        blk = 3'($urandom);
        mem = '{default: 8'h00};
        // a true rising edge, so the serial-clock flops see reset too
        #1 rst = 1'b1;
        repeat (8) @(negedge clk);
        chk({6'h00, busy, sda_out}, 8'h00);
        chk({7'h00, sda_oe_n}, 8'h01);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        ra = 11'h000;
        rread(1);
        for (int k = 4; k < 8; k++) begin
            sep_master_model_i.start();
            put(ctl(blk, 1'b0) ^ (8'h01 << k), 1'b0);
            sep_master_model_i.stop();
        end
        base = 11'($urandom);
        blk = base[10:8];
        wstart();
        for (int i = 0; i < 17; i++) begin
            d = 8'($urandom);
            put(d, 1'b1);
            mem[{base[10:4], base[3:0] + 4'(i)}] = d;
        end
        sep_master_model_i.stop();
        wait_busy(1'b1);
        sep_master_model_i.start();
        put(ctl(blk, 1'b0), 1'b0);
        sep_master_model_i.stop();
        wait_busy(1'b0);
        wp = 1'b1;
        wstart();
        put(8'($urandom), 1'b1);
        sep_master_model_i.stop();
        repeat (20) @(negedge clk);
        chk({7'h00, busy}, 8'h00);
        wp = 1'b0;
        wstart();
        for (int i = 0; i < 3; i++) begin
            sep_master_model_i.bitx(1'b1, ack);
        end
        ra = base;
        rread(3);
        rread(1);
        finish_test();
    end
endmodule : sep_eeprom_slave_bench
`default_nettype wire
